// ---- verification/rvq_line_src.sv ----
// Line-side model that sends ring threshold-crossing events
`timescale 1ns/100ps
module rvq_line_src (
  input wire logic clk,
  output logic ringCrossing
);
  initial ringCrossing = 1'b0;
  // Events come twice per ring period, so gap is half the period
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ringCrossing <= 1'b1;
      repeat (4) @(posedge clk);
      ringCrossing <= 1'b0;
      repeat (gap - 5) @(posedge clk);
    end
  endtask : burst
  // Plain level, used while validation is off
  task automatic level(input logic v);
    @(posedge clk);
    ringCrossing <= v;
  endtask : level
endmodule : rvq_line_src

// ---- verification/tb_top.sv ----
// Self-checking bench of the ring validation qualifier
`timescale 1ns/100ps
module tb_top;
  import rvq_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  localparam int TICKS = 20;
  localparam int START = 25;
  // Highest ring 33 Hz: 25 - 7.6 rounded up, plus 1 for margin
  localparam logic [5:0] MAXC = 6'd19;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, ringCrossing;
  logic ringDetectOut, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int errCount, nTests;
  rvq_qualifier #(.TICK_CYCLES(TICKS)) u_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ringCrossing(ringCrossing), .ringDetectOut(ringDetectOut), .irq(irq)
  );
  rvq_line_src u_src (.clk(clk), .ringCrossing(ringCrossing));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic testDone;
    $display("Checks %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : testDone
  // Read at the rising edge itself: the flops only change after this
  task automatic wait_ready;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : wait_ready
  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
    // Leave mid-cycle so callers see what the last edge wrote
    @(negedge clk);
  endtask : ahb
  task automatic rd_chk(input string what, input logic [7:0] idx,
                        input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    check(what, rd, exp);
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    errCount++;
    testDone();
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    errCount = 0;
    nTests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped index
    rd_chk("ctrl_a rst", IDX_CTRL_A, 32'h00);
    rd_chk("ctrl_b rst", IDX_CTRL_B, 32'h00);
    rd_chk("ctrl_c rst", IDX_CTRL_C, 32'h19);
    rd_chk("unmapped", 8'h30, 32'h0);
    // CTRL_A and CTRL_B fields read back, upper bits zero
    ahb(1'b1, IDX_CTRL_A, 32'hffff_ffff);
    rd_chk("ctrl_a all", IDX_CTRL_A, 32'hff);
    ahb(1'b1, IDX_CTRL_B, 32'h0000_01a5);
    rd_chk("ctrl_b mix", IDX_CTRL_B, 32'ha5);
    // Validation off: output follows the pin
    u_src.level(1'b1);
    repeat (6) @(posedge clk);
    check("follow hi", {31'h0, ringDetectOut}, 32'h1);
    u_src.level(1'b0);
    repeat (6) @(posedge clk);
    check("follow lo", {31'h0, ringDetectOut}, 32'h0);
    // Too fast: second event 4 ticks after the first
    ahb(1'b1, IDX_CTRL_A, {24'h0, 2'b00, MAXC});
    ahb(1'b1, IDX_CTRL_B, {24'h0, 1'b0, 4'd1, 3'd0});
    ahb(1'b1, IDX_CTRL_C, 32'h80 | START);
    u_src.burst(2, 4 * TICKS);
    repeat (10) @(posedge clk);
    rd_chk("too fast", IDX_IRQ_STATUS, 32'h2);
    rd_chk("idle", IDX_STATE, 32'h40 | (START - 5));
    check("irq masked", {31'h0, irq}, 32'h0);
    ahb(1'b1, IDX_IRQ_MASK, 32'h7);
    check("irq on", {31'h0, irq}, 32'h1);
    ahb(1'b1, IDX_IRQ_STATUS, 32'h2);
    check("irq off", {31'h0, irq}, 32'h0);
    // Valid ring: 10-tick spacing, 100 ms confirm, no delay
    fork
      u_src.burst(8, 10 * TICKS);
      begin
        repeat (800) @(posedge clk);
        check("confirming", {31'h0, ringDetectOut}, 32'h0);
      end
    join
    check("valid", {31'h0, ringDetectOut}, 32'h1);
    check("valid irq", {31'h0, irq}, 32'h1);
    // Ring over after 64 ticks of silence; timer rests at zero
    repeat (1500) @(posedge clk);
    check("over", {31'h0, ringDetectOut}, 32'h0);
    rd_chk("over stat", IDX_IRQ_STATUS, 32'h5);
    rd_chk("timer 0", IDX_STATE, 32'h40);
    ahb(1'b1, IDX_IRQ_STATUS, 32'h7);
    // Delay code 1 holds the indication 128 ticks past confirmation
    ahb(1'b1, IDX_CTRL_A, {24'h0, 2'b01, MAXC});
    ahb(1'b1, IDX_CTRL_B, {24'h0, 1'b0, 4'd2, 3'd0});
    fork
      u_src.burst(20, 10 * TICKS);
      begin
        repeat (3000) @(posedge clk);
        check("delaying", {31'h0, ringDetectOut}, 32'h0);
      end
    join
    check("delayed", {31'h0, ringDetectOut}, 32'h1);
    repeat (3000) @(posedge clk);
    ahb(1'b1, IDX_IRQ_STATUS, 32'h7);
    // Rectifier mode: a single crossing starts the one-shot
    ahb(1'b1, IDX_CTRL_C, 32'hc0 | START);
    u_src.burst(1, 10);
    repeat (1000) @(posedge clk);
    check("one-shot", {31'h0, ringDetectOut}, 32'h1);
    testDone();
  end
endmodule : tb_top

// ---- verilog/rvq_pkg.sv ----
// Constants, register map and types of the ring validation qualifier
package rvq_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_MS = 2;
  localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A = 8'h16;
  localparam logic [7:0] IDX_CTRL_B = 8'h17;
  localparam logic [7:0] IDX_CTRL_C = 8'h18;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h19;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1a;
  localparam logic [7:0] IDX_STATE = 8'h1b;
  localparam int ADDR_LSB = 2;

  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_C_RST = 8'h19;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Field positions
  localparam int A_DLY_HI = 7;
  localparam int A_DLY_LO = 6;
  localparam int A_MAX_HI = 5;
  localparam int B_DLY2 = 7;
  localparam int B_TO_HI = 6;
  localparam int B_TO_LO = 3;
  localparam int B_CONF_HI = 2;
  localparam int C_ENABLE = 7;
  localparam int C_RECT = 6;
  localparam int C_START_HI = 5;

  // Interrupt status bits
  localparam int IRQ_VALID = 0;
  localparam int IRQ_TOO_FAST = 1;
  localparam int IRQ_OVER = 2;

  // Times in milliseconds
  localparam int DELAY_STEP_MS = 256;
  localparam int TIMEOUT_STEP_MS = 128;
  localparam int ONE_SHOT_MS = 5000;
  localparam int CONF_MS_0 = 100;
  localparam int CONF_MS_1 = 150;
  localparam int CONF_MS_2 = 200;
  localparam int CONF_MS_3 = 256;
  localparam int CONF_MS_4 = 384;
  localparam int CONF_MS_5 = 512;
  localparam int CONF_MS_6 = 640;
  localparam int CONF_MS_7 = 1024;

  // Tick counts derived from the times
  localparam int DELAY_STEP_TICKS = DELAY_STEP_MS / TICK_MS;
  localparam int TIMEOUT_STEP_TICKS = TIMEOUT_STEP_MS / TICK_MS;
  localparam logic [11:0] ONE_SHOT_TICKS = 12'(ONE_SHOT_MS / TICK_MS);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_CONFIRM = 4'b0010,
    ST_DELAY   = 4'b0100,
    ST_VALID   = 4'b1000
  } rvq_state_e;

  typedef struct packed {
    logic enable;
    logic rectMode;
    logic [2:0] delayCode;
    logic [5:0] maxCount;
    logic [5:0] startVal;
    logic [3:0] timeoutCode;
    logic [2:0] confirmCode;
  } rvq_cfg_s;

endpackage : rvq_pkg

// ---- verilog/rvq_qualifier.sv ----
// Ring validation qualifier with AHB-Lite register slave
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module rvq_qualifier
  import rvq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ringCrossing,
  output logic ringDetectOut,
  output logic irq
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [9:0] confirmTicks(input logic [2:0] code);
    int ms;
    case (code)
      3'h0: ms = CONF_MS_0;
      3'h1: ms = CONF_MS_1;
      3'h2: ms = CONF_MS_2;
      3'h3: ms = CONF_MS_3;
      3'h4: ms = CONF_MS_4;
      3'h5: ms = CONF_MS_5;
      3'h6: ms = CONF_MS_6;
      default: ms = CONF_MS_7;
    endcase
    return 10'(ms / TICK_MS);
  endfunction : confirmTicks

  function automatic logic [9:0] stepTicks(input logic [3:0] code,
                                           input int step);
    return 10'(int'(code) * step);
  endfunction : stepTicks

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic [7:0] ctrlA_reg;
  logic [7:0] ctrlB_reg;
  logic [7:0] ctrlC_reg;
  logic [2:0] irqStatus_reg;
  logic [2:0] irqMask_reg;
  logic dpWrite_reg;
  logic rdWait_reg;
  logic [7:0] dpIndex_reg;
  logic [31:0] hrdata_reg;
  rvq_state_e state_reg;
  rvq_state_e state_next;
  logic [5:0] timer_reg;

  wire logic accept = hsel & htrans[1] & hready;
  wire logic [7:0] addrIndex = haddr[ADDR_LSB +: 8];
  wire logic wrA = dpWrite_reg & (dpIndex_reg == IDX_CTRL_A);
  wire logic wrB = dpWrite_reg & (dpIndex_reg == IDX_CTRL_B);
  wire logic wrC = dpWrite_reg & (dpIndex_reg == IDX_CTRL_C);
  wire logic wrStat = dpWrite_reg & (dpIndex_reg == IDX_IRQ_STATUS);
  wire logic wrMask = dpWrite_reg & (dpIndex_reg == IDX_IRQ_MASK);

  // Unmapped indices read zero and ignore writes
  logic [31:0] readMux;
  always_comb begin
    case (dpIndex_reg)
      IDX_CTRL_A: readMux = {24'h0, ctrlA_reg};
      IDX_CTRL_B: readMux = {24'h0, ctrlB_reg};
      IDX_CTRL_C: readMux = {24'h0, ctrlC_reg};
      IDX_IRQ_STATUS: readMux = {29'h0, irqStatus_reg};
      IDX_IRQ_MASK: readMux = {29'h0, irqMask_reg};
      IDX_STATE: readMux = {22'h0, state_reg, timer_reg};
      default: readMux = 32'h0;
    endcase
  end

  // Reads take one wait state so hrdata comes straight from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      dpWrite_reg <= 1'b0;
      rdWait_reg <= 1'b0;
      dpIndex_reg <= 8'h0;
      hrdata_reg <= 32'h0;
    end else begin
      dpWrite_reg <= accept & hwrite;
      rdWait_reg <= accept & ~hwrite;
      if (accept) begin
        dpIndex_reg <= addrIndex;
      end
      if (rdWait_reg) begin
        hrdata_reg <= readMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlA_reg <= CTRL_A_RST;
      ctrlB_reg <= CTRL_B_RST;
      ctrlC_reg <= CTRL_C_RST;
      irqMask_reg <= IRQ_RST;
    end else begin
      if (wrA) ctrlA_reg <= hwdata[7:0];
      if (wrB) ctrlB_reg <= hwdata[7:0];
      if (wrC) ctrlC_reg <= hwdata[7:0];
      if (wrMask) irqMask_reg <= hwdata[2:0];
    end
  end

  assign hreadyout = ~rdWait_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields

  rvq_cfg_s cfg;
  assign cfg.enable = ctrlC_reg[C_ENABLE];
  assign cfg.rectMode = ctrlC_reg[C_RECT];
  assign cfg.startVal = ctrlC_reg[C_START_HI:0];
  assign cfg.delayCode = {ctrlB_reg[B_DLY2],
                          ctrlA_reg[A_DLY_HI:A_DLY_LO]};
  assign cfg.maxCount = ctrlA_reg[A_MAX_HI:0];
  assign cfg.timeoutCode = ctrlB_reg[B_TO_HI:B_TO_LO];
  assign cfg.confirmCode = ctrlB_reg[B_CONF_HI:0];

  wire logic [9:0] delayTicks =
    stepTicks({1'b0, cfg.delayCode}, DELAY_STEP_TICKS);
  wire logic [9:0] timeoutTicks =
    stepTicks(cfg.timeoutCode, TIMEOUT_STEP_TICKS);
  wire logic [9:0] confTicks = confirmTicks(cfg.confirmCode);

  ////////////////////////////////////////////////////////////////////////////
  // Crossing input and tick

  logic crossSync1_reg;
  logic crossSync2_reg;
  logic crossPrev_reg;
  logic tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      crossSync1_reg <= 1'b0;
      crossSync2_reg <= 1'b0;
      crossPrev_reg <= 1'b0;
    end else begin
      crossSync1_reg <= ringCrossing;
      crossSync2_reg <= crossSync1_reg;
      crossPrev_reg <= crossSync2_reg;
    end
  end

  // One event per threshold crossing, two per ring period
  wire logic evt = crossSync2_reg & ~crossPrev_reg;

  rvq_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer and qualification

  logic [9:0] phase_reg;
  logic [9:0] quiet_reg;
  logic [11:0] shot_reg;

  // Timer still above max count means spacing below start minus max
  wire logic tooFast = evt & (state_reg != ST_IDLE)
                     & (timer_reg > cfg.maxCount);
  wire logic ringOver = (state_reg != ST_IDLE) & ~evt
                      & (quiet_reg >= timeoutTicks);
  wire logic confDone = (phase_reg >= confTicks);
  wire logic delayDone = (phase_reg >= delayTicks);

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_reg <= 6'h0;
    end else if (cfg.enable & evt) begin
      timer_reg <= cfg.startVal;
    end else if (tick && timer_reg != 6'h0) begin
      timer_reg <= timer_reg - 6'h1;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (evt) state_next = ST_CONFIRM;
      end
      ST_CONFIRM: begin
        if (tooFast | ringOver) state_next = ST_IDLE;
        else if (confDone) state_next = ST_DELAY;
      end
      ST_DELAY: begin
        if (tooFast | ringOver) state_next = ST_IDLE;
        else if (delayDone) state_next = ST_VALID;
      end
      ST_VALID: begin
        if (tooFast | ringOver) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!cfg.enable) state_next = ST_IDLE;
  end

  // Phase counts confirm time, then delay time, in ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      phase_reg <= 10'h0;
      quiet_reg <= 10'h0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        phase_reg <= 10'h0;
      end else if (tick) begin
        phase_reg <= phase_reg + 10'h1;
      end
      if (evt || state_reg == ST_IDLE) begin
        quiet_reg <= 10'h0;
      end else if (tick) begin
        quiet_reg <= quiet_reg + 10'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-shot and detect output

  always_ff @(posedge clk) begin
    if (rst) begin
      shot_reg <= 12'h0;
    end else if (cfg.enable & evt) begin
      shot_reg <= ONE_SHOT_TICKS;
    end else if (tick && shot_reg != 12'h0) begin
      shot_reg <= shot_reg - 12'h1;
    end
  end

  // Disabled: the output simply follows the synchronised detector level
  logic detect_next;
  assign detect_next = !cfg.enable ? crossSync2_reg
                     : cfg.rectMode ? (shot_reg != 12'h0)
                     : (state_reg == ST_VALID);

  always_ff @(posedge clk) begin
    if (rst) begin
      ringDetectOut <= 1'b0;
    end else begin
      ringDetectOut <= detect_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts; a new event wins over a same-cycle clear

  logic [2:0] irqEvents;
  assign irqEvents[IRQ_VALID] = (state_reg == ST_DELAY)
                              & (state_next == ST_VALID);
  assign irqEvents[IRQ_TOO_FAST] = tooFast & cfg.enable;
  assign irqEvents[IRQ_OVER] = ringOver & (state_reg == ST_VALID);

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus_reg <= IRQ_RST;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~({3{wrStat}} & hwdata[2:0]))
                     | irqEvents;
    end
  end

  assign irq = |(irqStatus_reg & irqMask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_timer_load: assert property (
    cfg.enable && evt |=> timer_reg == $past(cfg.startVal))
    else $error("Timer not loaded with start value on event");

  a_timer_step: assert property (
    !evt && tick && timer_reg != 6'h0 |=> timer_reg == $past(timer_reg) - 6'h1)
    else $error("Timer did not step down on tick");

  a_timer_floor: assert property (
    !evt && timer_reg == 6'h0 |=> timer_reg == 6'h0)
    else $error("Timer wrapped below zero");

  a_fast_reject: assert property (
    cfg.enable && state_reg != ST_IDLE && evt && timer_reg > cfg.maxCount
    |=> state_reg == ST_IDLE && irqStatus_reg[IRQ_TOO_FAST])
    else $error("Too fast ring not invalidated");

  a_slow_keep: assert property (
    state_reg == ST_VALID && evt && timer_reg <= cfg.maxCount && cfg.enable
    |=> state_reg == ST_VALID)
    else $error("Well spaced event dropped valid ring");

  a_disable_idle: assert property (
    !cfg.enable |=> state_reg == ST_IDLE)
    else $error("Qualifier active while disabled");

  a_quiet_bound: assert property (
    state_reg != ST_IDLE |-> quiet_reg <= timeoutTicks)
    else $error("Ring over not declared at timeout");

  a_confirm_end: assert property (
    state_reg == ST_CONFIRM && confDone |=> state_reg != ST_CONFIRM)
    else $error("Confirm phase overran its time");

  a_delay_hold: assert property (
    $rose(state_reg == ST_VALID) |-> $past(phase_reg) >= delayTicks)
    else $error("Valid ring indicated before delay");

  a_env_output: assert property (
    cfg.enable && !cfg.rectMode ##1 $stable(ctrlC_reg)
    |-> ringDetectOut == $past(state_reg == ST_VALID))
    else $error("Detect output not following envelope");

  a_shot_start: assert property (
    cfg.enable && evt |=> shot_reg == ONE_SHOT_TICKS)
    else $error("One-shot not started on crossing");

  c_ring_valid: cover property (@(posedge clk) disable iff (rst)
    $rose(state_reg == ST_VALID));
  c_ring_fast: cover property (@(posedge clk) disable iff (rst) tooFast);
  c_ring_over: cover property (@(posedge clk) disable iff (rst)
    irqEvents[IRQ_OVER]);
  c_irq_on: cover property (@(posedge clk) disable iff (rst) $rose(irq));

endmodule : rvq_qualifier

// ---- verilog/rvq_tick_gen.sv ----
// Divider that makes the one-cycle 2 ms tick enable
`timescale 1ns/100ps
module rvq_tick_gen #(
  parameter int TICK_CYCLES = 400000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] count_reg;
  wire logic wrap = (count_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 32'h0;
    end else begin
      count_reg <= wrap ? 32'h0 : count_reg + 32'h1;
    end
  end

  assign tick = wrap;
endmodule : rvq_tick_gen
